//--- logic/dtc_engine.sv
// direct transfer controller core: request capture, arbitration, descriptor
// fetch, data move, write-back and checksum.
// assumes three same-clock bus masters with word-only single transfers.
//
// Contract
// R1: up to twelve channels, each with triggers
// R2: triggered channels request the arbiter, nothing else
// R3: one granted channel at a time acts
// R4: fetch granted channel's descriptor before moving data
// R5: higher priority request pre-empts active channel
// R6: write back descriptor, then switch channel
// R7: completion raises selectable interrupt and event
// R8: payload traffic only on data port
// R9: separate fetch port; fetch precedes start/resume
// R10: write-back uses its own port
// R11: bus master ports follow the published bus
// R12: any peripheral/memory endpoint pairing allowed
// R13: software, event and peripheral triggers accepted
// R14: descriptors live in memory, one per transfer
// R15: descriptors link, closed chains make rings
// R16: checksum engine runs beside the transfers
// R17: highest priority wins, lowest index breaks ties
`timescale 1ns/1ps
`default_nettype none
module dtc_engine
  import dtc_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter int PW  = PRIO_W,
  parameter int CW  = $clog2(NCH)
) (
  input  wire logic              clk,        // core clock
  input  wire logic              rst_n,      // async reset, low
  input  wire logic [NCH-1:0]    ch_enable,  // channel may be triggered
  input  wire logic [NCH-1:0]    sw_trig,    // software trigger pulses
  input  wire logic [NCH-1:0]    evt_trig,   // event fabric triggers
  input  wire logic [NCH-1:0]    per_req,    // peripheral requests
  input  wire logic [NCH*PW-1:0] ch_prio,    // priority per channel
  input  wire logic [NCH-1:0]    irq_sel,    // completion interrupt select
  input  wire logic [NCH-1:0]    evt_sel,    // completion event select
  input  wire logic [31:0]       desc_base,  // first descriptor table
  input  wire logic [31:0]       wb_base,    // write-back table
  input  wire logic              crc_clear,  // restart checksum
  output logic [31:0]            f_haddr,    // fetch port address
  output logic [1:0]             f_htrans,   // fetch port transfer type
  input  wire logic [31:0]       f_hrdata,   // fetch port read data
  input  wire logic              f_hready,   // fetch port ready
  output logic [31:0]            d_haddr,    // data port address
  output logic [1:0]             d_htrans,   // data port transfer type
  output logic                   d_hwrite,   // data port direction
  output logic [31:0]            d_hwdata,   // data port write data
  input  wire logic [31:0]       d_hrdata,   // data port read data
  input  wire logic              d_hready,   // data port ready
  output logic [31:0]            w_haddr,    // write-back port address
  output logic [1:0]             w_htrans,   // write-back transfer type
  output logic [31:0]            w_hwdata,   // write-back write data
  input  wire logic              w_hready,   // write-back port ready
  output logic [NCH-1:0]         done_irq,   // completion interrupt pulse
  output logic [NCH-1:0]         done_evt,   // completion event pulse
  output logic [CW-1:0]          active_ch,  // channel being served
  output logic                   busy,       // engine not idle
  output logic [31:0]            crc_value   // running checksum
);
  // refuse channel counts outside one to twelve and priority widths below one
  if (NCH < 1 || NCH > 12 || PW < 1) begin : g_bad
    $error("channel count or priority width out of range");
  end

  state_t      state_reg, state_next;
  phase_t      phase_reg, phase_next;
  logic [1:0]  widx_reg, widx_next;
  logic [CW-1:0] act_reg;
  logic [PW-1:0] act_prio_reg;
  logic [31:0] desc_reg [DESC_WORDS];
  logic [31:0] cur_desc_reg [NCH];
  logic [31:0] data_reg;
  logic [31:0] crc_reg;
  logic [NCH-1:0] pend_reg, pend_next;
  logic [NCH-1:0] saved_reg, saved_next;
  logic [NCH-1:0] linked_reg, linked_next;
  logic [NCH-1:0] irq_reg, irq_next;
  logic [NCH-1:0] evt_reg, evt_next;
  logic [31:0] f_haddr_reg, d_haddr_reg, w_haddr_reg;
  logic [1:0]  f_htrans_reg, d_htrans_reg, w_htrans_reg;
  logic        d_hwrite_reg;
  logic [31:0] d_hwdata_reg, w_hwdata_reg;

  wire         gnt_valid;
  wire [CW-1:0] gnt_idx;
  wire [PW-1:0] gnt_prio;

  // requests go to the arbiter; the engine acts only on its grant
  dtc_arbiter #(.NCH(NCH), .PW(PW), .CW(CW)) u_arb (
    .req       (pend_reg),    // R2
    .prio      (ch_prio),
    .gnt_valid (gnt_valid),
    .gnt_idx   (gnt_idx),
    .gnt_prio  (gnt_prio)
  );

  // bus handshake decode, shared by the three ports
  wire        hready_sel = (state_reg == ST_FETCH) ? f_hready :
                           (state_reg == ST_WB) ? w_hready : d_hready;
  wire        busy_now   = state_reg != ST_IDLE;
  wire        is_issue   = busy_now && phase_reg == PH_ISSUE;
  wire        addr_acc   = busy_now && phase_reg == PH_ADDR && hready_sel;
  wire        beat_done  = busy_now && phase_reg == PH_DATA && hready_sel;
  wire        last_word  = widx_reg == 2'h3;

  // descriptor fields of the active channel
  wire [CNT_W-1:0] cnt      = desc_reg[DW_CTRL][CNT_LSB +: CNT_W];
  wire        desc_valid    = desc_reg[DW_CTRL][CTRL_VALID];
  wire        src_inc       = desc_reg[DW_CTRL][CTRL_SRC_INC];
  wire        dst_inc       = desc_reg[DW_CTRL][CTRL_DST_INC];
  wire [31:0] link_addr     = desc_reg[DW_NEXT];

  // event decode of the sequence
  wire fetch_beat = beat_done && state_reg == ST_FETCH;
  wire read_beat  = beat_done && state_reg == ST_READ;
  wire write_beat = beat_done && state_reg == ST_WRITE;
  wire wb_beat    = beat_done && state_reg == ST_WB;
  wire fetch_end  = fetch_beat && last_word;
  wire wb_end     = wb_beat && last_word;
  wire desc_empty = !desc_valid || cnt == '0;
  wire last_beat  = cnt == CNT_W'(1);
  wire preempt    = gnt_valid && gnt_prio > act_prio_reg;  // R5
  wire finish     = (fetch_end && desc_empty) || (write_beat && last_beat);

  // descriptor addresses: write-back slot when resuming, else chain or table
  wire [31:0] slot_off   = 32'(act_reg) << DESC_SHIFT;
  wire [31:0] word_off   = 32'({widx_reg, 2'h0});
  wire [31:0] chain_addr = linked_reg[act_reg] ? cur_desc_reg[act_reg]
                                               : desc_base + slot_off;  // R14
  wire [31:0] fetch_addr = (saved_reg[act_reg] ? wb_base + slot_off
                                               : chain_addr) + word_off;  // R9
  wire [31:0] wb_addr    = wb_base + slot_off + word_off;

  // word-serial checksum, one bit per loop step
  function automatic logic [31:0] crc_word(input logic [31:0] c,
                                           input logic [31:0] d);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int b = 31; b >= 0; b--) begin
      fb = r[31] ^ d[b];
      r  = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  // per-channel request, completion and resume bookkeeping
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire trig   = ch_enable[c] & (sw_trig[c] | evt_trig[c] | per_req[c]);  // R13
    wire is_act = act_reg == CW'(c);
    wire done_c = finish && is_act;
    // a trigger in the completion cycle survives: set wins over clear
    assign pend_next[c]   = trig | (pend_reg[c] & ~done_c);  // R1
    assign irq_next[c]    = done_c & irq_sel[c];  // R7
    assign evt_next[c]    = done_c & evt_sel[c];  // R7
    assign saved_next[c]  = (wb_end && is_act) |
                            (saved_reg[c] & ~(fetch_end && is_act));  // R6
    assign linked_next[c] = done_c ? link_addr != '0 : linked_reg[c];  // R15
  end

  // sequencer: grant, fetch, move, write back
  always_comb begin
    state_next = state_reg;
    widx_next  = widx_reg;
    unique case (state_reg)
      ST_IDLE: begin
        widx_next = 2'h0;
        if (gnt_valid) begin
          state_next = ST_FETCH;  // R4
        end
      end
      ST_FETCH: begin
        if (fetch_beat) begin
          widx_next = widx_reg + 2'h1;
          if (last_word) begin
            state_next = desc_empty ? ST_IDLE : ST_READ;  // R9
          end
        end
      end
      ST_READ: begin
        if (read_beat) begin
          state_next = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (write_beat) begin
          if (last_beat) begin
            state_next = ST_IDLE;
          end else if (preempt) begin
            state_next = ST_WB;  // R6
            widx_next  = 2'h0;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_WB: begin
        if (wb_beat) begin
          widx_next = widx_reg + 2'h1;
          if (last_word) begin
            state_next = ST_IDLE;  // R6
          end
        end
      end
    endcase
  end

  // bus phase: issue, address accepted, data accepted
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_ISSUE: phase_next = busy_now ? PH_ADDR : PH_ISSUE;
      PH_ADDR:  phase_next = hready_sel ? PH_DATA : PH_ADDR;
      PH_DATA:  phase_next = hready_sel ? PH_ISSUE : PH_DATA;
    endcase
    if (!busy_now) begin
      phase_next = PH_ISSUE;
    end
  end

  // control state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      phase_reg  <= PH_ISSUE;
      widx_reg   <= 2'h0;
      pend_reg   <= '0;
      saved_reg  <= '0;
      linked_reg <= '0;
      irq_reg    <= '0;
      evt_reg    <= '0;
    end else begin
      state_reg  <= state_next;
      phase_reg  <= phase_next;
      widx_reg   <= widx_next;
      pend_reg   <= pend_next;
      saved_reg  <= saved_next;
      linked_reg <= linked_next;
      irq_reg    <= irq_next;
      evt_reg    <= evt_next;
    end
  end

  // grant capture: only the granted channel becomes active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg      <= '0;
      act_prio_reg <= '0;
    end else if (state_reg == ST_IDLE && gnt_valid) begin
      act_reg      <= gnt_idx;  // R3
      act_prio_reg <= gnt_prio;
    end
  end

  // descriptor store: loaded by fetch, advanced by each written beat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DESC_WORDS; i++) begin
        desc_reg[i] <= WORD_RST;
      end
    end else if (fetch_beat) begin
      desc_reg[widx_reg] <= f_hrdata;  // R4
    end else if (write_beat) begin
      desc_reg[DW_CTRL][CNT_LSB +: CNT_W] <= cnt - CNT_W'(1);
      // fixed addresses serve peripheral endpoints, stepping ones memory
      desc_reg[DW_SRC] <= desc_reg[DW_SRC] + (src_inc ? WORD_BYTES : '0);  // R12
      desc_reg[DW_DST] <= desc_reg[DW_DST] + (dst_inc ? WORD_BYTES : '0);  // R12
    end
  end

  // chain pointer per channel; a link back to the head forms a ring
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        cur_desc_reg[i] <= WORD_RST;
      end
    end else if (finish && link_addr != '0) begin
      cur_desc_reg[act_reg] <= link_addr;  // R15
    end
  end

  // payload word and checksum; clear wins over a beat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= WORD_RST;
      crc_reg  <= CRC_INIT;
    end else begin
      if (read_beat) begin
        data_reg <= d_hrdata;
      end
      if (crc_clear) begin
        crc_reg <= CRC_INIT;
      end else if (write_beat) begin
        crc_reg <= crc_word(crc_reg, data_reg);  // R16
      end
    end
  end

  // descriptor fetch port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_haddr_reg  <= WORD_RST;
      f_htrans_reg <= HTRANS_IDLE;
    end else if (is_issue && state_reg == ST_FETCH) begin
      f_haddr_reg  <= fetch_addr;  // R9
      f_htrans_reg <= HTRANS_NSEQ;  // R11
    end else if (addr_acc && state_reg == ST_FETCH) begin
      f_htrans_reg <= HTRANS_IDLE;
    end
  end

  // payload port: reads the source, then writes the destination
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_haddr_reg  <= WORD_RST;
      d_htrans_reg <= HTRANS_IDLE;
      d_hwrite_reg <= 1'b0;
      d_hwdata_reg <= WORD_RST;
    end else if (is_issue && (state_reg == ST_READ || state_reg == ST_WRITE)) begin
      d_haddr_reg  <= state_reg == ST_READ ? desc_reg[DW_SRC] : desc_reg[DW_DST];  // R8
      d_hwrite_reg <= state_reg == ST_WRITE;
      d_htrans_reg <= HTRANS_NSEQ;  // R11
    end else if (addr_acc && (state_reg == ST_READ || state_reg == ST_WRITE)) begin
      d_htrans_reg <= HTRANS_IDLE;
      d_hwdata_reg <= data_reg;  // R8
    end
  end

  // write-back port, data follows the accepted address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_haddr_reg  <= WORD_RST;
      w_htrans_reg <= HTRANS_IDLE;
      w_hwdata_reg <= WORD_RST;
    end else if (is_issue && state_reg == ST_WB) begin
      w_haddr_reg  <= wb_addr;  // R10
      w_htrans_reg <= HTRANS_NSEQ;  // R11
    end else if (addr_acc && state_reg == ST_WB) begin
      w_htrans_reg <= HTRANS_IDLE;
      w_hwdata_reg <= desc_reg[widx_reg];  // R10
    end
  end

  // status flops
  logic [CW-1:0] active_reg;
  logic          busy_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= '0;
      busy_reg   <= 1'b0;
    end else begin
      active_reg <= act_reg;
      busy_reg   <= busy_now;
    end
  end

  assign f_haddr   = f_haddr_reg;
  assign f_htrans  = f_htrans_reg;
  assign d_haddr   = d_haddr_reg;
  assign d_htrans  = d_htrans_reg;
  assign d_hwrite  = d_hwrite_reg;
  assign d_hwdata  = d_hwdata_reg;
  assign w_haddr   = w_haddr_reg;
  assign w_htrans  = w_htrans_reg;
  assign w_hwdata  = w_hwdata_reg;
  assign done_irq  = irq_reg;
  assign done_evt  = evt_reg;
  assign active_ch = active_reg;
  assign busy      = busy_reg;
  assign crc_value = crc_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // grant goes only to a pending channel
  grant_pending_a: assert property (gnt_valid |-> pend_reg[gnt_idx]) // R3
    else $error("grant to a channel without request");
  // a peripheral request on enabled channel zero is pending next cycle
  trigger_pend_a: assert property (ch_enable[0] && per_req[0] |=> pend_reg[0]) // R13
    else $error("trigger lost");
  // reads only follow a fetch or a write
  fetch_first_a: assert property ($rose(state_reg == ST_READ) |->
    $past(state_reg) == ST_FETCH || $past(state_reg) == ST_WRITE) // R4
    else $error("data read without fetch");
  // write-back entered only from a written beat under higher priority
  preempt_prio_a: assert property ($rose(state_reg == ST_WB) |->
    $past(state_reg) == ST_WRITE && $past(preempt)) // R5
    else $error("write-back without pre-emption");
  // after write-back the channel is marked for resume
  wb_saved_a: assert property (wb_end |=> saved_reg[$past(act_reg)] && state_reg == ST_IDLE) // R6
    else $error("write-back did not park channel");
  // completion pulse lasts one cycle
  done_pulse_a: assert property ((irq_reg != '0) |=> irq_reg == '0 || $past(finish)) // R7
    else $error("interrupt pulse too long");
  // fetch port only active while fetching
  fetch_port_a: assert property (f_htrans_reg == HTRANS_NSEQ |-> state_reg == ST_FETCH) // R9
    else $error("fetch port used outside fetch");
  // write-back port only active in write-back
  wb_port_a: assert property (w_htrans_reg == HTRANS_NSEQ |-> state_reg == ST_WB) // R10
    else $error("write-back port used outside write-back");
  // a written beat lowers the count by exactly one
  count_step_a: assert property (write_beat && !last_beat |=> cnt == $past(cnt) - CNT_W'(1)) // R12
    else $error("beat count off");

  cover_preempt_c: cover property ($rose(state_reg == ST_WB));
  cover_chain_c:   cover property (finish && link_addr != '0);
  cover_done_c:    cover property (write_beat && last_beat);
endmodule
`default_nettype wire

//--- logic/dtc_pkg.sv
// shared constants of the direct transfer controller: descriptor layout,
// bus codes, checksum polynomial and the engine state encodings.
// assumes a single clock domain and word-only bus traffic.
package dtc_pkg;
  localparam int          NUM_CH       = 12;       // channel count
  localparam int          PRIO_W       = 2;        // priority field width
  localparam int          ADDR_W       = 32;       // bus address width
  localparam int          DESC_WORDS   = 4;        // words per descriptor
  localparam int          DESC_SHIFT   = 4;        // log2 of descriptor bytes
  localparam int          DW_CTRL      = 0;        // control word index
  localparam int          DW_SRC       = 1;        // source address index
  localparam int          DW_DST       = 2;        // destination address index
  localparam int          DW_NEXT      = 3;        // link address index
  localparam int          CTRL_VALID   = 0;        // descriptor valid bit
  localparam int          CTRL_SRC_INC = 1;        // source increments
  localparam int          CTRL_DST_INC = 2;        // destination increments
  localparam int          CNT_LSB      = 16;       // beat count position
  localparam int          CNT_W        = 16;       // beat count width
  localparam logic [31:0] WORD_BYTES   = 32'h4;    // address step per beat
  localparam logic [1:0]  HTRANS_IDLE  = 2'h0;     // bus idle code
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;     // bus non-sequential code
  localparam logic [31:0] CRC_POLY     = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [31:0] WORD_RST     = 32'h00000000;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_READ, ST_WRITE, ST_WB} state_t;
  typedef enum logic [1:0] {PH_ISSUE, PH_ADDR, PH_DATA} phase_t;
endpackage

//--- logic/dtc_arbiter.sv
// priority arbiter of the transfer controller: picks one pending channel.
// assumes stable requests within the cycle.
`timescale 1ns/1ps
`default_nettype none
module dtc_arbiter
  import dtc_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter int PW  = PRIO_W,
  parameter int CW  = $clog2(NCH)
) (
  input  wire logic [NCH-1:0]    req,       // pending channel requests
  input  wire logic [NCH*PW-1:0] prio,      // priority per channel
  output logic                   gnt_valid, // some channel wins
  output logic [CW-1:0]          gnt_idx,   // winning channel
  output logic [PW-1:0]          gnt_prio   // winner's priority
);
  // scan downward with >= so the lowest index wins among equals
  always_comb begin
    gnt_valid = 1'b0;
    gnt_idx   = '0;
    gnt_prio  = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i] && (!gnt_valid || prio[i*PW +: PW] >= gnt_prio)) begin // R17
        gnt_valid = 1'b1;
        gnt_idx   = CW'(i);
        gnt_prio  = prio[i*PW +: PW];
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/mem_model.sv
// shared memory behind the three master ports
// assumes word transfers, answers 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import dtc_pkg::*;
(
  input  wire logic        clk,      // core clock
  input  wire logic        stall,    // random wait states when high
  input  wire logic [31:0] f_haddr,  // fetch address
  input  wire logic [1:0]  f_htrans, // fetch transfer type
  output logic [31:0]      f_hrdata, // fetch read data
  output logic             f_hready, // fetch ready
  input  wire logic [31:0] d_haddr,  // data address
  input  wire logic [1:0]  d_htrans, // data transfer type
  input  wire logic        d_hwrite, // data direction
  input  wire logic [31:0] d_hwdata, // data write word
  output logic [31:0]      d_hrdata, // data read data
  output logic             d_hready, // data ready
  input  wire logic [31:0] w_haddr,  // write-back address
  input  wire logic [1:0]  w_htrans, // write-back transfer type
  input  wire logic [31:0] w_hwdata, // write-back word
  output logic             w_hready  // write-back ready
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] pa [3];
  logic        pw [3];
  logic        ph [3] = '{0, 0, 0};
  logic        rdy [3] = '{1, 1, 1};
  logic [31:0] rd [3] = '{0, 0, 0};
  int          cnt [3] = '{0, 0, 0}; // accepted addresses per port
  logic [31:0] ad [3];
  logic [1:0]  tr [3];
  logic        wr [3];
  logic [31:0] wd [3];

  task automatic put(input logic [31:0] a, input logic [31:0] v);
    mem[a] = v;
  endtask
  function automatic logic [31:0] get(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'hDEAD0000 ^ a;
  endfunction

  assign f_hrdata = rd[0];
  assign f_hready = rdy[0];
  assign d_hrdata = rd[1];
  assign d_hready = rdy[1];
  assign w_hready = rdy[2];

  // ready ends the data phase and takes the next address
  always @(posedge clk) begin
    ad = '{f_haddr, d_haddr, w_haddr};
    tr = '{f_htrans, d_htrans, w_htrans};
    wr = '{1'b0, d_hwrite, 1'b1};
    wd = '{32'h0, d_hwdata, w_hwdata};
    for (int p = 0; p < 3; p++) begin
      if (rdy[p]) begin
        if (ph[p] && pw[p]) mem[pa[p]] = wd[p];
        ph[p] = (tr[p] == HTRANS_NSEQ);
        pa[p] = ad[p];
        pw[p] = wr[p];
        if (ph[p]) cnt[p]++;
      end
    end
    #1;
    // no read data phase: a changing word
    for (int p = 0; p < 3; p++) begin
      rdy[p] = stall ? 1'($urandom_range(0, 1)) : 1'b1;
      rd[p] = (ph[p] && !pw[p]) ? get(pa[p]) : ~rd[p];
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench of the transfer engine
// assumes mem_model serves all three ports from one store
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module tb_top
  import dtc_pkg::*;
;
  logic                     clk = 0, rst_n = 0, crc_clear = 0, stall = 0;
  logic [NUM_CH-1:0]        ch_enable = '1, irq_sel = '1, evt_sel = 0;
  logic [NUM_CH-1:0]        sw_trig = 0, evt_trig = 0, per_req = 0, done_irq, done_evt;
  logic [NUM_CH*PRIO_W-1:0] ch_prio = 0;
  logic [31:0]              desc_base = 32'h1000, wb_base = 32'h2000;
  logic [31:0]              f_haddr, f_hrdata, d_haddr, d_hwdata, d_hrdata, w_haddr, w_hwdata;
  logic [31:0]              crc_value, exp_c, t;
  logic [1:0]               f_htrans, d_htrans, w_htrans;
  logic                     f_hready, d_hready, d_hwrite, w_hready, busy;
  logic [$clog2(NUM_CH)-1:0] active_ch;
  logic [31:0]              pay [NUM_CH][8];
  int                       exp_q [$];
  int                       n_mismatch = 0, n_compared = 0, cyc = 0;
  int                       c0 [3];

  mem_model mdl (.clk, .stall, .f_haddr, .f_htrans, .f_hrdata, .f_hready, .d_haddr, .d_htrans,
    .d_hwrite, .d_hwdata, .d_hrdata, .d_hready, .w_haddr, .w_htrans, .w_hwdata, .w_hready);
  dtc_engine dut (.clk, .rst_n, .ch_enable, .sw_trig, .evt_trig, .per_req, .ch_prio, .irq_sel,
    .evt_sel, .desc_base, .wb_base, .crc_clear, .f_haddr, .f_htrans, .f_hrdata, .f_hready,
    .d_haddr, .d_htrans, .d_hwrite, .d_hwdata, .d_hrdata, .d_hready, .w_haddr, .w_htrans,
    .w_hwdata, .w_hready, .done_irq, .done_evt, .active_ch, .busy, .crc_value);

  always #2 clk = ~clk;

  function automatic logic [31:0] src(input int c); return 32'h4000 + 32'(c) * 32'h100; endfunction
  function automatic logic [31:0] dst(input int c); return 32'h8000 + 32'(c) * 32'h100; endfunction
  function automatic logic [31:0] slot(input int c); return desc_base + 32'(16 * c); endfunction
  // checksum, msb first
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
    return c;
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one-cycle trigger of one source kind
  task automatic fire(input logic [NUM_CH-1:0] m, input int k);
    @(posedge clk);
    #1;
    if (k == 0) sw_trig = m;
    else if (k == 1) evt_trig = m;
    else per_req = m;
    @(posedge clk);
    #1;
    {sw_trig, evt_trig, per_req} = 0;
  endtask
  // table-slot descriptor and random payload
  task automatic desc(input int c, input int n, input logic [2:0] fl, input logic [31:0] nx);
    for (int i = 0; i < n; i++) begin
      pay[c][i] = $urandom;
      mdl.put(src(c) + 32'(4 * i), pay[c][i]);
    end
    mdl.put(slot(c), {16'(n), 13'h0, fl});
    mdl.put(slot(c) + 32'h4, src(c));
    mdl.put(slot(c) + 32'h8, dst(c));
    mdl.put(slot(c) + 32'hC, nx);
  endtask
  // bounded wait for completions and idle
  task automatic settle(input string nm);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 3000 && (exp_q.size() > 0 || busy !== 1'b0); k++) @(posedge clk);
    #1;
    `CHK(exp_q.size(), 0);
    $display("test %s done", nm);
  endtask
  task automatic dst_ok(input int c, input int n);
    for (int i = 0; i < n; i++) `CHK(mdl.get(dst(c) + 32'(4 * i)), pay[c][i]);
  endtask

  // completion watcher: oldest note per pulse
  always @(posedge clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst_n && done_irq[c] === 1'b1) begin
        exp_c = exp_q.size() > 0 ? exp_q.pop_front() : -1;
        `CHK(c, exp_c);
        `CHK(active_ch, c);
        `CHK(done_evt[c], evt_sel[c]);
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    void'($urandom(32'h8107));
    evt_sel = NUM_CH'($urandom);
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    `CHK(crc_value, CRC_INIT);
    `CHK({f_htrans, d_htrans, w_htrans, busy}, 0);
    // each trigger source, stalls only for the event trigger
    for (int k = 0; k < 3; k++) begin
      stall = k[0];
      desc(4 * k + 1, 3, 3'h7, 0);
      exp_q.push_back(4 * k + 1);
      c0 = mdl.cnt;
      fire(NUM_CH'(1) << (4 * k + 1), k);
      settle("source kind");
      dst_ok(4 * k + 1, 3);
      `CHK(mdl.cnt[0] - c0[0], DESC_WORDS);
      `CHK(mdl.cnt[1] - c0[1], 6);
      `CHK(mdl.cnt[2] - c0[2], 0);
    end
    // a disabled channel never reaches the arbiter
    ch_enable[11] = 0;
    c0 = mdl.cnt;
    fire(NUM_CH'(1) << 11, 0);
    repeat (20) @(posedge clk);
    #1;
    `CHK(mdl.cnt[0] - c0[0], 0);
    ch_enable[11] = 1;
    // priority first, then lower index
    ch_prio[9:8] = 2'h2;
    ch_prio[19:18] = 2'h2;
    ch_prio[3:2] = 2'h1;
    desc(4, 2, 3'h7, 0);
    desc(9, 2, 3'h7, 0);
    desc(1, 2, 3'h7, 0);
    exp_q = '{4, 9, 1};
    fire(NUM_CH'(12'h212), 1);
    settle("arbitration");
    // pre-emption: write-back, switch, resume
    ch_prio = 0;
    ch_prio[13:12] = 2'h3;
    stall = 1;
    desc(0, 8, 3'h7, 0);
    desc(6, 2, 3'h7, 0);
    exp_q = '{6, 0};
    c0 = mdl.cnt;
    fire(NUM_CH'(1), 2);
    for (int k = 0; k < 500 && mdl.cnt[1] - c0[1] < 4; k++) @(posedge clk);
    fire(NUM_CH'(1) << 6, 0);
    settle("pre-emption");
    `CHK(mdl.cnt[2] - c0[2], DESC_WORDS);
    t = mdl.get(wb_base);
    `CHK(mdl.get(wb_base + 32'h4) + 32'(4 * t[31:16]), src(0) + 32'h20);
    `CHK(mdl.get(wb_base + 32'h8) - mdl.get(wb_base + 32'h4), dst(0) - src(0));
    dst_ok(0, 8);
    dst_ok(6, 2);
    // fixed destination and fresh checksum
    stall = 0;
    crc_clear = 1;
    @(posedge clk);
    #1;
    crc_clear = 0;
    desc(2, 4, 3'h3, 0);
    exp_q = '{2};
    fire(NUM_CH'(1) << 2, 0);
    settle("fixed address");
    `CHK(mdl.get(dst(2)), pay[2][3]);
    t = CRC_INIT;
    for (int i = 0; i < 4; i++) t = crc_upd(t, pay[2][i]);
    `CHK(crc_value, t);
    // empty descriptor: no data traffic
    desc(3, 0, 3'h1, 0);
    exp_q = '{3};
    c0 = mdl.cnt;
    fire(NUM_CH'(1) << 3, 1);
    settle("empty descriptor");
    `CHK(mdl.cnt[1] - c0[1], 0);
    // second trigger follows the link
    desc(7, 2, 3'h7, 32'h3000);
    mdl.put(32'h3000, 32'h0002_0007);
    mdl.put(32'h3004, src(7));
    mdl.put(32'h3008, 32'h7000);
    mdl.put(32'h300C, 32'h0);
    exp_q = '{7};
    fire(NUM_CH'(1) << 7, 0);
    settle("link first");
    exp_q = '{7};
    fire(NUM_CH'(1) << 7, 2);
    settle("link second");
    `CHK(mdl.get(32'h7004), pay[7][1]);
    results();
  end
endmodule
`undef CHK
`default_nettype wire
